// ### rtl/tp_host.sv
`timescale 1ns/1ps
`default_nettype none
module tp_host
   import tp_pkg::*;
#(
   parameter int DW = 12
)(
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          nrst_in,
   // pattern request
   input  wire logic          start_in,
   input  wire mode_e         mode_in,
   input  wire logic [DW-1:0] custom_in,
   input  wire logic [15:0]   cfg_in,
   output logic               busy_out,
   output logic               done_out,
   // received data check
   output logic [DW-1:0]      rx_word_out,
   output logic               rx_match_out,
   // link to the device
   tp_link_if.host            link
);

   // serial sequencer states
   typedef enum logic [2:0] {
      TX_IDLE,
      TX_START,
      TX_HIGH,
      TX_LOW,
      TX_END,
      TX_GAP
   } tx_e;

   // whole state of the host end
   typedef struct packed {
      tx_e          tx;       // sequencer state
      logic [3:0]   div;      // half-period divider
      logic [1:0]   step;     // which of the four writes
      logic [4:0]   bits;     // bits sent in this frame
      logic [23:0]  word;     // frame being shifted out
      mode_e        mode;     // latched request
      logic [DW-1:0] cust;    // latched custom pattern
      logic [15:0]  cfg;      // latched configuration word
      logic         sdenb_n;  // frame enable
      logic         sclk;     // serial clock
      logic         done;     // sequence finished pulse
      logic [DW-1:0] rx;      // captured channel a word
      logic         match;    // captured word is an expected one
   } host_s;

   host_s st_r;
   host_s st_nxt;

   // frame for a write step: config first, then the three pattern words
   function automatic logic [23:0] frame_of(input logic [1:0] s, input mode_e m,
                                            input logic [DW-1:0] c, input logic [15:0] g);
      logic [15:0] w;
      logic [6:0]  a;
      w = W_ZERO;
      a = ADDR_CFG;
      case (s)
         2'd0: begin
            // fast mode off for patterns, back on for normal output; other bits pass
            w                = g;
            w[HPM_FIRST_BIT] = (m == MODE_NORMAL); // R2 R8
         end
         2'd1: begin
            a = ADDR_CONTROL;
            case (m)
               MODE_ZEROS:  w = W_CTL_ZERO;
               MODE_ONES:   w = W_CTL_ONE;
               MODE_TOG_AA: w = W_CTL_AA;
               MODE_TOG_FF: w = W_CTL_ONE;
               MODE_CUSTOM: w = W_CTL_ZERO; // R7
               default:     w = W_ZERO; // R8
            endcase
         end
         2'd2: begin
            a = ADDR_VALUE;
            case (m)
               MODE_ONES:   w = W_VAL_ONE;
               MODE_TOG_AA: w = W_VAL_AA;
               MODE_CUSTOM: w = {2'b00, c, 2'b00}; // R7
               default:     w = W_ZERO;
            endcase
         end
         default: begin
            a = ADDR_ALTERN;
            case (m)
               MODE_ONES, MODE_TOG_FF: w = W_VAL_ONE;
               MODE_TOG_AA:            w = W_ALT_55;
               default:                w = W_ZERO;
            endcase
         end
      endcase
      frame_of = {1'b0, a, w};
   endfunction

   logic          tick;   // one half period elapsed
   logic [23:0]   f0;     // expected value word frame
   logic [23:0]   f1;     // expected alternate word frame

   // sequencer, divider and receive checker
   always_comb begin
      st_nxt      = st_r;
      st_nxt.done = 1'b0;
      tick        = (st_r.div == 4'(SCLK_HALF_CYC - 1));
      f0          = frame_of(2'd2, st_r.mode, st_r.cust, st_r.cfg);
      f1          = frame_of(2'd3, st_r.mode, st_r.cust, st_r.cfg);
      if (st_r.tx != TX_IDLE) begin
         st_nxt.div = tick ? 4'd0 : st_r.div + 4'd1;
      end
      case (st_r.tx)
         TX_IDLE: begin
            if (start_in) begin
               st_nxt.tx      = TX_START;
               st_nxt.mode    = mode_in;
               st_nxt.cust    = custom_in;
               st_nxt.cfg     = cfg_in;
               st_nxt.step    = 2'd0;
               st_nxt.word    = frame_of(2'd0, mode_in, custom_in, cfg_in);
               st_nxt.sdenb_n = 1'b0;
               st_nxt.div     = '0;
               st_nxt.bits    = '0;
            end
         end
         TX_START, TX_LOW: begin
            if (tick) begin
               st_nxt.tx   = TX_HIGH;
               st_nxt.sclk = 1'b1;
            end
         end
         TX_HIGH: begin
            if (tick) begin
               st_nxt.sclk = 1'b0;
               st_nxt.bits = st_r.bits + 5'd1;
               st_nxt.word = {st_r.word[22:0], 1'b0};
               st_nxt.tx   = (st_r.bits == 5'(FRAME_BITS - 1)) ? TX_END : TX_LOW;
            end
         end
         TX_END: begin
            if (tick) begin
               st_nxt.sdenb_n = 1'b1;
               st_nxt.tx      = TX_GAP;
            end
         end
         TX_GAP: begin
            // every sequence writes all three pattern registers
            if (tick) begin
               if (st_r.step == 2'd3) begin // R3
                  st_nxt.tx   = TX_IDLE;
                  st_nxt.done = 1'b1;
               end else begin
                  st_nxt.step    = st_r.step + 2'd1;
                  st_nxt.word    = frame_of(st_r.step + 2'd1, st_r.mode, st_r.cust, st_r.cfg);
                  st_nxt.bits    = '0;
                  st_nxt.sdenb_n = 1'b0;
                  st_nxt.tx      = TX_START;
               end
            end
         end
         default: begin
            st_nxt.tx = TX_IDLE;
         end
      endcase
      // capture and compare against both pattern words
      st_nxt.rx    = link.data_a;
      st_nxt.match = (link.data_a == f0[PAT_MSB:PAT_LSB]) |
                     (link.data_a == f1[PAT_MSB:PAT_LSB]);
   end

   // state register
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r.tx      <= TX_IDLE;
         st_r.div     <= '0;
         st_r.step    <= '0;
         st_r.bits    <= '0;
         st_r.word    <= '0;
         st_r.mode    <= MODE_NORMAL;
         st_r.cust    <= '0;
         st_r.cfg     <= CFG_RST;
         st_r.sdenb_n <= 1'b1;
         st_r.sclk    <= 1'b0;
         st_r.done    <= 1'b0;
         st_r.rx      <= '0;
         st_r.match   <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign link.sdenb_n = st_r.sdenb_n;
   assign link.sclk    = st_r.sclk;
   assign link.sdio    = st_r.word[23];
   assign busy_out     = (st_r.tx != TX_IDLE);
   assign done_out     = st_r.done;
   assign rx_word_out  = st_r.rx;
   assign rx_match_out = st_r.match;

endmodule // tp_host
`default_nettype wire

// ### include/tp_pkg.sv
`default_nettype none
package tp_pkg;
   // register map of the serial programming port (7-bit addresses)
   localparam logic [6:0]  ADDR_CFG      = 7'h01;
   localparam logic [6:0]  ADDR_CONTROL  = 7'h3c;
   localparam logic [6:0]  ADDR_VALUE    = 7'h3d;
   localparam logic [6:0]  ADDR_ALTERN   = 7'h3e;
   // field positions
   localparam int          HPM_FIRST_BIT = 1;
   localparam int          CTL_EN_BIT    = 15;
   localparam int          CTL_OFF_BIT   = 14;
   localparam int          PAT_MSB       = 13;
   localparam int          PAT_LSB       = 2;
   // reset values
   localparam logic [15:0] CFG_RST       = 16'h0002;
   localparam logic [15:0] PAT_RST       = 16'h0000;
   // serial frame: r/w bit, 7 address bits, 16 data bits
   localparam int          FRAME_BITS    = 24;
   // serial timing: 20 MHz max, so 25 ns per half period
   localparam int          CLK_MHZ       = 250;
   localparam int          SCLK_HALF_NS  = 25;
   localparam int          SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
   // pattern register words
   localparam logic [15:0] W_CTL_ZERO    = 16'h8000;
   localparam logic [15:0] W_CTL_ONE     = 16'hbffc;
   localparam logic [15:0] W_VAL_ONE     = 16'h3ffc;
   localparam logic [15:0] W_CTL_AA      = 16'h9554;
   localparam logic [15:0] W_VAL_AA      = 16'h2aa8;
   localparam logic [15:0] W_ALT_55      = 16'h1554;
   localparam logic [15:0] W_ZERO        = 16'h0000;
   // pattern selections requested by the host user
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_ZEROS,
      MODE_ONES,
      MODE_TOG_AA,
      MODE_TOG_FF,
      MODE_CUSTOM
   } mode_e;
endpackage
`default_nettype wire

// ### include/tp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface tp_link_if #(parameter int DW = 12);
   logic          sdenb_n;   // serial frame enable, low during a frame
   logic          sclk;      // serial clock, made by the host
   logic          sdio;      // serial data, host to device
   logic [DW-1:0] data_a;    // channel a output word
   logic [DW-1:0] data_b;    // channel b output word
   logic          dclk;      // output word clock
   modport dev  (input sdenb_n, sclk, sdio, output data_a, data_b, dclk);
   modport host (output sdenb_n, sclk, sdio, input data_a, data_b, dclk);
endinterface
`default_nettype wire

// ### rtl/tp_device.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R1 - device offers selectable known output test patterns
// R2 - host clears fast-mode bit before patterns
// R3 - host programs all three pattern registers
// R4 - fixed words give all-zero or all-one output
// R5 - given words alternate 0xaaa and 0x555
// R6 - given words alternate 0xfff and 0x000
// R7 - custom pattern field layout and zero bits
// R8 - host restores fast-mode bit, zeros patterns
// R9 - patterns replace samples, output clock keeps running
module tp_device
   import tp_pkg::*;
#(
   parameter int DW = 12
)(
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          nrst_in,
   // converted samples from the converter core
   input  wire logic [DW-1:0] sample_a_in,
   input  wire logic [DW-1:0] sample_b_in,
   // register state seen by the core
   output logic               hp_first_out,
   output logic               pattern_on_out,
   // link to the receiving logic and host
   tp_link_if.dev             link
);

   // serial receiver states
   // hold waits out surplus clocks until the enable rises
   typedef enum logic [1:0] {
      RX_IDLE,
      RX_SHIFT,
      RX_HOLD
   } rx_e;

   // whole state of the device end
   // one packed word, so the next-state process fills a single copy
   typedef struct packed {
      rx_e                  rx;        // serial receiver state
      logic                 sclk_q;    // last sampled serial clock
      logic [FRAME_BITS-1:0] shift;    // incoming frame bits
      logic [4:0]           cnt;       // bits taken in this frame
      logic [15:0]          cfg;       // configuration word, holds fast-mode bit
      logic [15:0]          ctl;       // pattern control word
      logic [15:0]          val;       // pattern value word
      logic [15:0]          alt;       // pattern alternate word
      logic                 phase;     // which pattern word goes out next
      logic [DW-1:0]        dat_a;     // registered channel a word
      logic [DW-1:0]        dat_b;     // registered channel b word
      logic                 dclk;      // output word clock
   } dev_s;

   // all device state sits in one register, so reset and capture stay in one place
   dev_s st_r;    // registered state
   dev_s st_nxt;  // next state

   // pattern field of a pattern register
   function automatic logic [DW-1:0] pat_field(input logic [15:0] w);
      pat_field = w[PAT_MSB:PAT_LSB];
   endfunction

   // pattern mode needs the enable bit set, the off bit clear and fast mode off;
   // gating on the fast-mode bit means a host that skips clearing it sees samples,
   // a safer failure than a half-configured pattern
   function automatic logic pat_active(input logic [15:0] c, input logic [15:0] g);
      pat_active = c[CTL_EN_BIT] & ~c[CTL_OFF_BIT] & ~g[HPM_FIRST_BIT]; // R2 R7
   endfunction

   // helper values, all worked out at the top of the next-state process
   logic          sclk_rise;  // rising edge of the serial clock
   logic          last_bit;   // this edge completes the frame
   logic [23:0]   frame;      // frame including the bit being taken
   logic [6:0]    waddr;      // address of a completed frame
   logic [15:0]   wdata;      // data of a completed frame
   logic          active;     // pattern substitution on
   logic [DW-1:0] pat_word;   // pattern word for this cycle

   // next-state logic for the receiver, register file and output path
   always_comb begin
      // hold everything unless a branch below says otherwise
      st_nxt    = st_r;
      sclk_rise = link.sclk & ~st_r.sclk_q;
      // cnt counts bits already taken, so 23 means this edge brings the 24th
      last_bit  = (st_r.cnt == 5'(FRAME_BITS - 1));
      frame     = {st_r.shift[FRAME_BITS-2:0], link.sdio};
      waddr     = frame[22:16];
      wdata     = frame[15:0];
      active    = pat_active(st_r.ctl, st_r.cfg);
      // alternate between the value and alternate words every sample
      pat_word  = st_r.phase ? pat_field(st_r.alt) : pat_field(st_r.val);

      // keep the last serial clock; an edge shows as a one now and a zero before
      st_nxt.sclk_q = link.sclk;

      // serial frame receiver
      // a short frame is dropped whole, so a glitch on the enable cannot half-write
      if (link.sdenb_n) begin
         // enable high ends any frame, a short frame is dropped
         st_nxt.rx  = RX_IDLE;
         st_nxt.cnt = '0;
      end else begin
         case (st_r.rx)
            RX_IDLE: begin
               // frame starts, first rising edge carries the r/w bit
               st_nxt.rx = RX_SHIFT;
               if (sclk_rise) begin
                  st_nxt.shift = frame;
                  st_nxt.cnt   = 5'd1;
               end
            end
            RX_SHIFT: begin
               // one bit per rising serial clock edge, msb first
               if (sclk_rise) begin
                  st_nxt.shift = frame;
                  st_nxt.cnt   = st_r.cnt + 5'd1;
                  // the 24th bit completes the frame and commits the write
                  if (last_bit) begin
                     st_nxt.rx = RX_HOLD;
                     // only writes change registers, other addresses are ignored;
                     // read frames are swallowed too since the data pin is one-way
                     if (!frame[23]) begin
                        case (waddr)
                           // configuration word, the fast-mode bit lives here
                           ADDR_CFG: begin
                              st_nxt.cfg = wdata; // R2 R8
                           end
                           // pattern words are stored whole, reserved bits unchecked
                           ADDR_CONTROL: begin
                              st_nxt.ctl = wdata; // R3 R7
                           end
                           ADDR_VALUE: begin
                              st_nxt.val = wdata; // R3 R7
                           end
                           ADDR_ALTERN: begin
                              st_nxt.alt = wdata; // R3 R7
                           end
                           default: begin
                              // unmapped address: the frame is counted and dropped
                              st_nxt.cnt = st_r.cnt + 5'd1;
                           end
                        endcase
                     end
                  end
               end
            end
            RX_HOLD: begin
               // extra clocks after a full frame wait for the enable to rise
               st_nxt.rx = RX_HOLD;
            end
            default: begin
               st_nxt.rx = RX_IDLE;
            end
         endcase
      end

      // output path: pattern words replace samples while active
      if (active) begin
         // both channels carry the same word so either lane can be checked
         st_nxt.dat_a = pat_word; // R1 R4 R5 R6 R9
         st_nxt.dat_b = pat_word; // R9
         // phase flips every cycle, which gives the two-word alternation
         st_nxt.phase = ~st_r.phase; // R5 R6
      end else begin
         // normal conversion data, one register stage like the pattern path
         st_nxt.dat_a = sample_a_in;
         st_nxt.dat_b = sample_b_in;
         // restart so a pattern switched on from normal output opens with the value word
         st_nxt.phase = 1'b0;
      end

      // word clock toggles every cycle in either mode
      // so the receiver never loses its clock when patterns switch on or off
      st_nxt.dclk = ~st_r.dclk; // R9
   end

   // single state register, cleared to known values on reset
   // the reset values are a choice of this block; the testbench checks hp_first_out, pattern_on_out and data_a under reset
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_r.rx     <= RX_IDLE;
         st_r.sclk_q <= 1'b0;
         st_r.shift  <= '0;
         st_r.cnt    <= '0;
         st_r.cfg    <= CFG_RST;
         st_r.ctl    <= PAT_RST;
         st_r.val    <= PAT_RST;
         st_r.alt    <= PAT_RST;
         st_r.phase  <= 1'b0;
         st_r.dat_a  <= '0;
         st_r.dat_b  <= '0;
         st_r.dclk   <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // link outputs straight from the state register, so the receiver sees clean words
   assign link.data_a    = st_r.dat_a; // R9
   assign link.data_b    = st_r.dat_b; // R9
   assign link.dclk      = st_r.dclk;  // R9

   // register state for the core; pattern_on_out is decoded from registers and
   // therefore leads the first pattern word on the link by one cycle
   assign hp_first_out   = st_r.cfg[HPM_FIRST_BIT];
   assign pattern_on_out = pat_active(st_r.ctl, st_r.cfg); // R1

endmodule // tp_device
`default_nettype wire

// ### bench/tp_link_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tp_link_monitor
   import tp_pkg::*;
#(
   parameter int DW = 12
)(
   // clock and reset
   input  wire logic          mclk_in,
   input  wire logic          nrst_in,
   // serial programming wires
   input  wire logic          sdenb_n,
   input  wire logic          sclk,
   input  wire logic          sdio,
   // output word side
   input  wire logic [DW-1:0] data_a,
   input  wire logic [DW-1:0] data_b,
   input  wire logic          dclk,
   input  wire logic          pattern_on_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   logic [5:0] rise_cnt_r;  // serial clock rises seen in the open frame
   logic       sclk_d_r;    // serial clock one cycle back

   // count bit edges per frame; cleared while idle so a short frame shows up
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rise_cnt_r <= '0;
         sclk_d_r   <= 1'b0;
      end else begin
         sclk_d_r <= sclk;
         if (sdenb_n) begin
            rise_cnt_r <= '0;
         end else if (sclk && !sclk_d_r) begin
            rise_cnt_r <= rise_cnt_r + 6'd1;
         end
      end
   end

   AST_DCLK_RUNS: assert property (
      $past(nrst_in) |-> dclk != $past(dclk))
      else $error("word clock stopped");
   AST_SAME_CHANNELS: assert property (
      pattern_on_out && $past(pattern_on_out) |-> data_a == data_b)
      else $error("channels differ in pattern mode");
   AST_ALTERNATION: assert property (
      (pattern_on_out && sdenb_n)[*4] |-> data_a == $past(data_a, 2))
      else $error("pattern does not repeat every two words");
   AST_IDLE_SCLK: assert property (
      sdenb_n |-> !sclk)
      else $error("serial clock moves outside a frame");
   AST_WRITE_FRAME: assert property (
      $fell(sdenb_n) |-> !sdio)
      else $error("frame does not start as a write");
   AST_SCLK_HIGH: assert property (
      $rose(sclk) |-> sclk[*7] ##1 !sclk)
      else $error("serial clock high phase wrong length");
   AST_SDIO_STABLE: assert property (
      sclk && $past(sclk) |-> $stable(sdio))
      else $error("serial data moved while clock high");
   AST_FRAME_BITS: assert property (
      $rose(sdenb_n) |-> rise_cnt_r == 6'(FRAME_BITS))
      else $error("frame not 24 bits");
   AST_FRAME_GAP: assert property (
      $rose(sdenb_n) |-> sdenb_n[*7])
      else $error("gap between frames too short");

   // main scenarios reached
   cover property (pattern_on_out && data_a == '1);
   cover property ($rose(sdenb_n));
   cover property ($fell(pattern_on_out));
endmodule // tp_link_monitor
`default_nettype wire

// ### bench/adc_output_test_pattern_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module adc_output_test_pattern_control_tb_top;
   import tp_pkg::*;
   // stimulus
   logic        mclk_in   = 1'b0;
   logic        nrst_in   = 1'b0;
   logic        start_in  = 1'b0;
   mode_e       mode_in   = MODE_NORMAL;
   logic [11:0] custom_in = 12'h000;
   logic [15:0] cfg_in    = 16'h0000;
   logic [11:0] sample_in = 12'h0123;  // constant so normal output is predictable
   logic [11:0] sample_b_word = 12'h0456; // differs from channel a so a lane mix-up shows
   // observed
   logic        hp_first_out;
   logic        pattern_on_out;
   logic        busy_out;
   logic        done_out;
   logic        rx_match_out;
   logic [11:0] rx_word_out;
   // bookkeeping
   int          num_errors = 0;
   int          num_checks = 0;
   int          cycles     = 0;

   // 250 MHz clock
   always #2 mclk_in = ~mclk_in;

   tp_link_if #(.DW(12)) link ();

   tp_device #(.DW(12)) tp_device_i (
      .mclk_in(mclk_in), .nrst_in(nrst_in),
      .sample_a_in(sample_in), .sample_b_in(sample_b_word),
      .hp_first_out(hp_first_out), .pattern_on_out(pattern_on_out),
      .link(link.dev));

   tp_host #(.DW(12)) tp_host_i (
      .mclk_in(mclk_in), .nrst_in(nrst_in),
      .start_in(start_in), .mode_in(mode_in), .custom_in(custom_in), .cfg_in(cfg_in),
      .busy_out(busy_out), .done_out(done_out),
      .rx_word_out(rx_word_out), .rx_match_out(rx_match_out),
      .link(link.host));

   tp_link_monitor #(.DW(12)) tp_link_monitor_i (
      .mclk_in(mclk_in), .nrst_in(nrst_in),
      .sdenb_n(link.sdenb_n), .sclk(link.sclk), .sdio(link.sdio),
      .data_a(link.data_a), .data_b(link.data_b), .dclk(link.dclk),
      .pattern_on_out(pattern_on_out));

   // verdict and end of run
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // compare an output word
   task automatic check_val(input logic [11:0] got, input logic [11:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // compare a flag
   task automatic check_bit(input logic got, input logic exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one host request, optional refused second start, then two output words
   task automatic run(input mode_e m, input logic [11:0] c, input logic [15:0] g,
                      input logic poke, input logic [11:0] v, input logic [11:0] a,
                      input logic hp);
      logic [11:0] x;
      logic [11:0] y;
      int          n;
      @(posedge mclk_in);
      start_in  <= 1'b1;
      mode_in   <= m;
      custom_in <= c;
      cfg_in    <= g;
      @(posedge mclk_in);
      start_in  <= 1'b0;
      // the request is taken at this edge, so the host must now be busy
      @(negedge mclk_in);
      check_bit(busy_out, 1'b1);
      // a start while busy must leave the running request untouched
      if (poke) begin
         repeat (40) @(posedge mclk_in);
         start_in <= 1'b1;
         mode_in  <= MODE_ONES;
         @(posedge mclk_in);
         start_in <= 1'b0;
      end
      n = 0;
      do begin
         @(negedge mclk_in);
         n++;
      end while (done_out !== 1'b1 && n < 3000);
      check_bit(done_out, 1'b1);
      check_bit(busy_out, 1'b0);
      repeat (3) @(negedge mclk_in);
      check_bit(done_out, 1'b0);
      x = link.data_a;
      check_val(link.data_b, hp ? sample_b_word : x);
      @(negedge mclk_in);
      y = link.data_a;
      // either phase of the alternation is fine, the order must hold
      check_val(x, (x === a) ? a : v);
      check_val(y, (x === a) ? v : a);
      check_val(rx_word_out, (x === a) ? a : v);
      check_bit(hp_first_out, hp);
      check_bit(pattern_on_out, !hp);
      check_bit(rx_match_out, !hp);
   endtask

   // hang guard, the full sequence needs about 11300 cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // main sequence
   initial begin
      repeat (2) @(negedge mclk_in);
      check_bit(hp_first_out, 1'b1);
      check_bit(pattern_on_out, 1'b0);
      check_bit(link.sdenb_n, 1'b1);
      check_val(link.data_a, 12'h000);
      repeat (4) @(posedge mclk_in);
      nrst_in <= 1'b1;
      run(MODE_ZEROS, 12'h000, 16'h0002, 1'b0, 12'h000, 12'h000, 1'b0);
      run(MODE_ONES, 12'h000, 16'h0002, 1'b0, 12'hfff, 12'hfff, 1'b0);
      run(MODE_TOG_AA, 12'h000, 16'h0002, 1'b0, 12'haaa, 12'h555, 1'b0);
      run(MODE_TOG_FF, 12'h000, 16'h0002, 1'b0, 12'hfff, 12'h000, 1'b0);
      run(MODE_CUSTOM, 12'ha5c, 16'h0002, 1'b0, 12'ha5c, 12'h000, 1'b0);
      run(MODE_CUSTOM, 12'h800, 16'hffff, 1'b0, 12'h800, 12'h000, 1'b0);
      run(MODE_ZEROS, 12'h000, 16'h0002, 1'b1, 12'h000, 12'h000, 1'b0);
      run(MODE_NORMAL, 12'h000, 16'h0000, 1'b0, 12'h123, 12'h123, 1'b1);
      report_and_stop();
   end
endmodule // adc_output_test_pattern_control_tb_top
`default_nettype wire
